// ### rtl/dct_pkg.sv
// Constants and types for the dual channel 8-bit timer
//------------------------------------------------------------
//------------------------------------------------------------
package dct_pkg;
    localparam int DCT_TIMERS = 2;
    localparam int DCT_CHANS = 2;
    localparam int DCT_PINS = 4;
    localparam int DCT_ADDR_W = 12;

    // Register indices; byte address is four times the index
    localparam logic [7:0] DCT_IDX_T3_COUNT = 8'hca;
    localparam logic [7:0] DCT_IDX_T3_CTL = 8'hcb;
    localparam logic [7:0] DCT_IDX_T3_CH0_CTL = 8'hcc;
    localparam logic [7:0] DCT_IDX_T3_CH0_VAL = 8'hcd;
    localparam logic [7:0] DCT_IDX_T3_CH1_CTL = 8'hce;
    localparam logic [7:0] DCT_IDX_T3_CH1_VAL = 8'hcf;
    localparam logic [7:0] DCT_IDX_FLAGS = 8'hd8;
    localparam logic [7:0] DCT_IDX_T4_COUNT = 8'hea;
    localparam logic [7:0] DCT_IDX_T4_CTL = 8'heb;
    localparam logic [7:0] DCT_IDX_T4_CH0_CTL = 8'hec;
    localparam logic [7:0] DCT_IDX_T4_CH0_VAL = 8'hed;
    localparam logic [7:0] DCT_IDX_T4_CH1_CTL = 8'hee;
    localparam logic [7:0] DCT_IDX_T4_CH1_VAL = 8'hef;
    localparam logic [7:0] DCT_IDX_COUNT [DCT_TIMERS] = '{DCT_IDX_T3_COUNT, DCT_IDX_T4_COUNT};
    localparam logic [7:0] DCT_IDX_CTL [DCT_TIMERS] = '{DCT_IDX_T3_CTL, DCT_IDX_T4_CTL};
    localparam logic [7:0] DCT_IDX_CHCTL [DCT_PINS] = '{DCT_IDX_T3_CH0_CTL,
        DCT_IDX_T3_CH1_CTL, DCT_IDX_T4_CH0_CTL, DCT_IDX_T4_CH1_CTL};
    localparam logic [7:0] DCT_IDX_CHVAL [DCT_PINS] = '{DCT_IDX_T3_CH0_VAL,
        DCT_IDX_T3_CH1_VAL, DCT_IDX_T4_CH0_VAL, DCT_IDX_T4_CH1_VAL};

    // Timer control fields
    localparam int DCT_CTL_DIV_LSB = 5;
    localparam int DCT_CTL_RUN = 4;
    localparam int DCT_CTL_WRAPIM = 3;
    localparam int DCT_CTL_ZERO = 2;
    localparam int DCT_CTL_MODE_LSB = 0;
    localparam logic [7:0] DCT_CTL_RST = 8'h08;
    localparam logic [7:0] DCT_CTL_KEEP = 8'hfb;

    // Channel control fields
    localparam int DCT_CH_IM = 6;
    localparam int DCT_CH_CMP_LSB = 3;
    localparam int DCT_CH_FUNC = 2;
    localparam int DCT_CH_EDGE_LSB = 0;
    localparam logic [7:0] DCT_CHCTL_RST = 8'h40;
    localparam logic [7:0] DCT_CHCTL_KEEP = 8'h7f;

    // Shared flag register fields
    localparam int DCT_FLAG_W = 6;
    localparam int DCT_FLAG_PER_TMR = 3;
    localparam int DCT_FLG_OTHER = 6;
    localparam logic [5:0] DCT_FLAGS_RST = 6'h00;
    localparam logic DCT_OTHER_RST = 1'b1;

    typedef enum logic [1:0] {
        DCT_MODE_FREE = 2'b00,
        DCT_MODE_DOWN = 2'b01,
        DCT_MODE_MOD = 2'b10,
        DCT_MODE_UPDN = 2'b11
    } dct_mode_e;

    typedef enum logic [2:0] {
        DCT_ACT_SET = 3'b000,
        DCT_ACT_CLR = 3'b001,
        DCT_ACT_TGL = 3'b010,
        DCT_ACT_SETUP = 3'b011,
        DCT_ACT_CLRUP = 3'b100,
        DCT_ACT_SETFF = 3'b101,
        DCT_ACT_CLRZ = 3'b110,
        DCT_ACT_INIT = 3'b111
    } dct_act_e;
endpackage

// ### rtl/dct_timer.sv
// Dual channel 8-bit timer with APB register access
`timescale 1ns/100ps
module dct_timer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dct_pkg::DCT_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Global tick enable
    input wire logic tick_en,
    // Channel pins, timer 3 ch0, ch1, timer 4 ch0, ch1
    input wire logic [dct_pkg::DCT_PINS-1:0] chan_in,
    output logic [dct_pkg::DCT_PINS-1:0] chan_out,
    output logic [dct_pkg::DCT_PINS-1:0] chan_oe,
    // Interrupt requests and other timer mask
    output logic [dct_pkg::DCT_TIMERS-1:0] timer_irq,
    output logic other_timer_wrap_mask
);
    import dct_pkg::*;

    //--------------------------------------------------------
    // APB decode
    //--------------------------------------------------------
    logic setup, acc, addr_ok, wr_acc, rd_hit, sel_flags;
    logic [7:0] idx, rd_val;

    assign idx = paddr[9:2];
    assign addr_ok = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
    assign setup = psel && !penable;
    assign acc = psel && penable;
    assign wr_acc = acc && pwrite && pstrb[0] && addr_ok;
    assign sel_flags = wr_acc && (idx == DCT_IDX_FLAGS);
    assign pready = 1'b1;
    assign pslverr = acc && !(addr_ok && rd_hit);

    //--------------------------------------------------------
    // Shared state between timers and bus
    //--------------------------------------------------------
    logic [7:0] t_rd [DCT_TIMERS];
    logic t_hit [DCT_TIMERS];
    logic [7:0] cctl_w [DCT_PINS];
    logic [7:0] val_w [DCT_PINS];
    logic [DCT_FLAG_W-1:0] ev_vec;
    logic [DCT_FLAG_W-1:0] flags;

    //--------------------------------------------------------
    // Shared flag register
    //--------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= DCT_FLAGS_RST;
        end else if (sel_flags) begin
            flags <= (flags & pwdata[DCT_FLAG_W-1:0]) | ev_vec;
        end else begin
            flags <= flags | ev_vec;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            other_timer_wrap_mask <= DCT_OTHER_RST;
        end else if (sel_flags) begin
            other_timer_wrap_mask <= pwdata[DCT_FLG_OTHER];
        end
    end

    //--------------------------------------------------------
    // Read path
    //--------------------------------------------------------
    always_comb begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
        if (idx == DCT_IDX_FLAGS) begin
            rd_hit = 1'b1;
            rd_val = {1'b0, other_timer_wrap_mask, flags};
        end else if (t_hit[0]) begin
            rd_hit = 1'b1;
            rd_val = t_rd[0];
        end else if (t_hit[1]) begin
            rd_hit = 1'b1;
            rd_val = t_rd[1];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= {24'h00_0000, rd_val};
        end
    end

    //--------------------------------------------------------
    // Timers
    //--------------------------------------------------------
    for (genvar t = 0; t < DCT_TIMERS; t++) begin : g_tmr
        logic [7:0] ctl;
        logic [7:0] cnt;
        logic [7:0] next_cnt;
        logic [7:0] top;
        logic [6:0] pre;
        logic [6:0] pre_mask;
        logic [2:0] div;
        logic [1:0] ch_ev;
        logic [1:0] ch_irq;
        logic run, step, stepped, up, next_up, loaded, next_loaded;
        logic wrap, wrap_ev, sel_ctl, zero_strb, updn;
        dct_mode_e mode;

        assign sel_ctl = wr_acc && (idx == DCT_IDX_CTL[t]);
        assign zero_strb = sel_ctl && pwdata[DCT_CTL_ZERO];
        assign div = ctl[DCT_CTL_DIV_LSB +: 3];
        assign run = ctl[DCT_CTL_RUN];
        assign mode = dct_mode_e'(ctl[DCT_CTL_MODE_LSB +: 2]);
        assign updn = (mode == DCT_MODE_UPDN);
        assign top = val_w[DCT_CHANS*t];

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ctl <= DCT_CTL_RST;
            end else if (sel_ctl) begin
                ctl <= pwdata[7:0] & DCT_CTL_KEEP;
            end
        end

        // Prescaler
        assign pre_mask = 7'h7f >> (3'd7 - div);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pre <= 7'h00;
            end else if (zero_strb) begin
                pre <= 7'h00;
            end else if (tick_en) begin
                pre <= pre + 7'h01;
            end
        end
        assign step = tick_en && ((pre & pre_mask) == pre_mask) && run;

        // Next count
        always_comb begin
            next_cnt = cnt;
            next_up = up;
            next_loaded = loaded;
            wrap = 1'b0;
            case (mode)
                DCT_MODE_FREE: begin
                    next_cnt = cnt + 8'h01;
                    wrap = (cnt == 8'hfe);
                end
                DCT_MODE_DOWN: begin
                    if (!loaded) begin
                        next_cnt = top;
                        next_loaded = 1'b1;
                        wrap = (top == 8'h00);
                    end else if (cnt != 8'h00) begin
                        next_cnt = cnt - 8'h01;
                        wrap = (cnt == 8'h01);
                    end
                end
                DCT_MODE_MOD: begin
                    next_cnt = (cnt == top) ? 8'h00 : cnt + 8'h01;
                    wrap = (cnt == 8'hfe) && (cnt != top);
                end
                DCT_MODE_UPDN: begin
                    if (up) begin
                        if (cnt >= top && cnt != 8'h00) begin
                            next_cnt = cnt - 8'h01;
                            next_up = 1'b0;
                            wrap = (cnt == 8'h01);
                        end else if (cnt < top) begin
                            next_cnt = cnt + 8'h01;
                        end
                    end else if (cnt != 8'h00) begin
                        next_cnt = cnt - 8'h01;
                        wrap = (cnt == 8'h01);
                    end
                    if (wrap || cnt == 8'h00) begin
                        next_up = 1'b1;
                    end
                end
                default: begin
                    next_cnt = cnt;
                end
            endcase
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt <= 8'h00;
                up <= 1'b1;
                loaded <= 1'b0;
            end else if (zero_strb) begin
                cnt <= 8'h00;
                up <= 1'b1;
                loaded <= 1'b0;
            end else if (!run) begin
                loaded <= 1'b0;
            end else if (step) begin
                cnt <= next_cnt;
                up <= next_up;
                loaded <= next_loaded;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                stepped <= 1'b0;
            end else begin
                stepped <= step && !zero_strb;
            end
        end

        assign wrap_ev = step && wrap && !zero_strb;
        assign ev_vec[DCT_FLAG_PER_TMR*t +: 3] = {ch_ev, wrap_ev};
        assign timer_irq[t] = (wrap_ev && ctl[DCT_CTL_WRAPIM]) || (|ch_irq);

        // Register read for this timer
        always_comb begin
            t_hit[t] = 1'b1;
            if (idx == DCT_IDX_COUNT[t]) begin
                t_rd[t] = cnt;
            end else if (idx == DCT_IDX_CTL[t]) begin
                t_rd[t] = ctl;
            end else if (idx == DCT_IDX_CHCTL[DCT_CHANS*t]) begin
                t_rd[t] = cctl_w[DCT_CHANS*t];
            end else if (idx == DCT_IDX_CHVAL[DCT_CHANS*t]) begin
                t_rd[t] = val_w[DCT_CHANS*t];
            end else if (idx == DCT_IDX_CHCTL[DCT_CHANS*t+1]) begin
                t_rd[t] = cctl_w[DCT_CHANS*t+1];
            end else if (idx == DCT_IDX_CHVAL[DCT_CHANS*t+1]) begin
                t_rd[t] = val_w[DCT_CHANS*t+1];
            end else begin
                t_rd[t] = 8'h00;
                t_hit[t] = 1'b0;
            end
        end

        //----------------------------------------------------
        // Channels
        //----------------------------------------------------
        for (genvar c = 0; c < DCT_CHANS; c++) begin : g_ch
            localparam int N = DCT_CHANS*t + c;
            logic [7:0] cctl;
            logic [7:0] val;
            logic [7:0] pend_val;
            logic [2:0] act;
            logic [1:0] edge_sel;
            logic pend;
            logic sync1;
            logic sync2;
            logic sync3;
            logic lvl;
            logic lvl_q;
            logic cap_ev;
            logic match;
            logic zhit;
            logic fhit;
            logic out;
            logic next_out;
            logic init_v;
            logic init_req;
            logic cmp_md;
            logic sel_cctl;
            logic sel_val;

            assign sel_cctl = wr_acc && (idx == DCT_IDX_CHCTL[N]);
            assign sel_val = wr_acc && (idx == DCT_IDX_CHVAL[N]);
            assign act = cctl[DCT_CH_CMP_LSB +: 3];
            assign edge_sel = cctl[DCT_CH_EDGE_LSB +: 2];
            assign cmp_md = cctl[DCT_CH_FUNC];
            assign init_req = sel_cctl && (pwdata[DCT_CH_CMP_LSB +: 3] == DCT_ACT_INIT);
            assign init_v = (act == DCT_ACT_CLR) || (act == DCT_ACT_CLRUP) ||
                (act == DCT_ACT_CLRZ);

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cctl <= DCT_CHCTL_RST;
                end else if (sel_cctl) begin
                    cctl <= pwdata[7:0] & DCT_CHCTL_KEEP;
                    if (init_req) begin
                        cctl[DCT_CH_CMP_LSB +: 3] <= act;
                    end
                end
            end

            // Pin synchroniser and filter
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1 <= 1'b0;
                    sync2 <= 1'b0;
                    sync3 <= 1'b0;
                    lvl <= 1'b0;
                    lvl_q <= 1'b0;
                end else begin
                    sync1 <= chan_in[N];
                    sync2 <= sync1;
                    sync3 <= sync2;
                    if (sync2 == sync3) begin
                        lvl <= sync3;
                    end
                    lvl_q <= lvl;
                end
            end

            assign cap_ev = !cmp_md && run && ((edge_sel[0] && lvl && !lvl_q) ||
                (edge_sel[1] && !lvl && lvl_q));
            assign match = cmp_md && stepped && (cnt == val);
            assign zhit = cmp_md && stepped && (cnt == 8'h00);
            assign fhit = cmp_md && stepped && (cnt == 8'hff);
            assign ch_ev[c] = cap_ev || match;
            assign ch_irq[c] = ch_ev[c] && cctl[DCT_CH_IM];

            // Capture/compare value
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    val <= 8'h00;
                    pend <= 1'b0;
                    pend_val <= 8'h00;
                end else begin
                    if (sel_val && cmp_md) begin
                        pend <= 1'b1;
                        pend_val <= pwdata[7:0];
                    end else if (pend && cnt == 8'h00) begin
                        pend <= 1'b0;
                        val <= pend_val;
                    end
                    if (sel_val && !cmp_md) begin
                        val <= pwdata[7:0];
                    end
                    if (cap_ev) begin
                        val <= cnt;
                    end
                end
            end

            // Compare output action
            always_comb begin
                next_out = out;
                case (dct_act_e'(act))
                    DCT_ACT_SET: if (match) next_out = 1'b1;
                    DCT_ACT_CLR: if (match) next_out = 1'b0;
                    DCT_ACT_TGL: if (match) next_out = !out;
                    DCT_ACT_SETUP: begin
                        if (updn) begin
                            if (match) next_out = up;
                        end else begin
                            if (zhit) next_out = 1'b0;
                            if (match) next_out = 1'b1;
                        end
                    end
                    DCT_ACT_CLRUP: begin
                        if (updn) begin
                            if (match) next_out = !up;
                        end else begin
                            if (zhit) next_out = 1'b1;
                            if (match) next_out = 1'b0;
                        end
                    end
                    DCT_ACT_SETFF: begin
                        if (fhit) next_out = 1'b0;
                        if (match) next_out = 1'b1;
                    end
                    DCT_ACT_CLRZ: begin
                        if (zhit) next_out = 1'b1;
                        if (match) next_out = 1'b0;
                    end
                    default: next_out = out;
                endcase
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    out <= 1'b0;
                end else if (zero_strb || init_req) begin
                    out <= init_v;
                end else if (cmp_md) begin
                    out <= next_out;
                end
            end

            assign chan_out[N] = out;
            assign chan_oe[N] = cmp_md;
            assign cctl_w[N] = cctl;
            assign val_w[N] = val;
        end
    end

endmodule

// ### tb/dct_pins.sv
// Pin side model: external drivers meet the timer outputs
`timescale 1ns/100ps
module dct_pins (
    // Levels
    input wire logic [dct_pkg::DCT_PINS-1:0] ext_lvl,
    input wire logic [dct_pkg::DCT_PINS-1:0] chan_out,
    input wire logic [dct_pkg::DCT_PINS-1:0] chan_oe,
    output logic [dct_pkg::DCT_PINS-1:0] chan_in
);
    import dct_pkg::*;
    // Device drive wins while enabled
    always_comb begin
        for (int i = 0; i < DCT_PINS; i++) begin
            chan_in[i] = chan_oe[i] ? chan_out[i] : ext_lvl[i];
        end
    end
endmodule

// ### tb/dct_properties.sv
// Port checker for the dual channel timer
`timescale 1ns/100ps
module dct_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dct_pkg::DCT_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Pins and mask
    input wire logic [dct_pkg::DCT_PINS-1:0] chan_oe,
    input wire logic other_timer_wrap_mask
);
    import dct_pkg::*;
    logic [7:0] last_wd;
    logic chw_seen;
    logic flw_seen;
    logic wr_now;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------
    // Access decode
    // ------------------------------
    assign wr_now = psel && penable && pwrite && pstrb[0] && paddr[11:10] == 2'b00;
    sequence acc(logic [7:0] ix);
        psel && penable && paddr == {2'b00, ix, 2'b00};
    endsequence
    sequence wr(logic [7:0] ix);
        acc(ix) ##0 pwrite && pstrb[0];
    endsequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_wd <= 8'h00;
            chw_seen <= 1'b0;
            flw_seen <= 1'b0;
        end else begin
            last_wd <= pwdata[7:0];
            chw_seen <= wr_now && paddr[1:0] == 2'b00 && (paddr[9:2] inside {DCT_IDX_CHCTL});
            flw_seen <= wr_now && paddr[1:0] == 2'b00 && paddr[9:2] == DCT_IDX_FLAGS;
        end
    end
    // ------------------------------
    // Properties
    // ------------------------------
    flag_top_zero_a: assert property (acc(8'hd8) ##0 !pwrite |-> !prdata[7])
        else $error("flag register bit 7 read as one");
    strobe_reads_zero_a: assert property ((acc(8'hcb) or acc(8'heb)) ##0 !pwrite |-> !prdata[2])
        else $error("zero strobe read as one");
    other_mask_write_a: assert property (wr(8'hd8) |=> other_timer_wrap_mask == last_wd[6])
        else $error("other mask not written");
    other_mask_hold_a: assert property ($changed(other_timer_wrap_mask) |-> flw_seen)
        else $error("other mask changed without write");
    oe_first_write_a: assert property (wr(8'hcc) |=> chan_oe[0] == last_wd[2])
        else $error("pin 0 enable wrong after write");
    oe_last_write_a: assert property (wr(8'hee) |=> chan_oe[3] == last_wd[2])
        else $error("pin 3 enable wrong after write");
    oe_hold_a: assert property ($changed(chan_oe) |-> chw_seen)
        else $error("pin enable changed without write");
    count_write_ok_a: assert property ((acc(8'hca) or acc(8'hea)) |-> !pslverr)
        else $error("count register access refused");
    reset_state_a: assert property ($rose(presetn) |-> other_timer_wrap_mask && chan_oe == 4'h0)
        else $error("wrong state after reset");
endmodule
bind dct_timer dct_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pslverr, .chan_oe, .other_timer_wrap_mask);

// ### tb/dct_timer_tb.sv
// Self-checking bench for the dual channel timer
`timescale 1ns/100ps
module dct_timer_tb;
    import dct_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, tick_en, er, other;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed;
    logic [3:0] pstrb, ext, chan_in, chan_out, chan_oe;
    logic [1:0] timer_irq;
    logic [7:0] rq;
    wire pready, pslverr;
    int fails, n_compared, irq_n, irq_z;
    dct_timer i_dct_timer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .tick_en, .chan_in, .chan_out, .chan_oe, .timer_irq,
        .other_timer_wrap_mask(other));
    dct_pins i_dct_pins (.ext_lvl(ext), .chan_out, .chan_oe, .chan_in);
    // ------------------------------
    // Helpers
    // ------------------------------
    function automatic int rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return int'(seed[15:0]);
    endfunction
    function automatic logic [7:0] exp_cnt(input logic [1:0] m, input int top, input int n);
        case (m)
            2'd0: return 8'(n % 256);
            2'd1: return (n == 0 || n > top) ? 8'h00 : 8'(top - n + 1);
            2'd2: return 8'(n % (top + 1));
            default: return 8'((n % (2 * top)) <= top ? n % (2 * top) : 2 * top - n % (2 * top));
        endcase
    endfunction
    function automatic int exp_wrap(input logic [1:0] m, input int top, input int s);
        case (m)
            2'd0: return (s + 1) / 256;
            2'd1: return int'(s > top);
            2'd2: return 0;
            default: return s / (2 * top);
        endcase
    endfunction
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] v);
        n_compared++;
        if (v !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", s, e, v);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, a, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rq = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            tick_en <= 1'b1;
            @(posedge pclk);
            tick_en <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task automatic close_out();
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ------------------------------
    // Stimulus
    // ------------------------------
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (timer_irq[1] === 1'b1) begin
            irq_n++;
        end
        if (timer_irq[0] === 1'b1) begin
            irq_z++;
        end
    end
    initial begin
        repeat (40000) @(posedge pclk);
        fails++;
        close_out();
    end
    initial begin
        int top, dv, n, n1, n2, v, k;
        logic [1:0] m;
        logic [2:0] a;
        {presetn, psel, penable, pwrite, tick_en, paddr, pwdata, ext} <= '0;
        pstrb <= 4'hf;
        seed = 32'd16144;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, DCT_IDX_CHCTL[i], 8'h0);
            chk("chctl reset", 8'h40, rq);
            apb(1'b0, DCT_IDX_CHVAL[i], 8'h0);
            chk("value reset", 8'h00, rq);
        end
        for (int i = 0; i < 2; i++) begin
            apb(1'b0, DCT_IDX_CTL[i], 8'h0);
            chk("ctl reset", 8'h08, rq);
            apb(1'b1, DCT_IDX_COUNT[i], 8'h5a);
            apb(1'b0, DCT_IDX_COUNT[i], 8'h0);
            chk("count read only", 8'h00, rq);
        end
        apb(1'b0, DCT_IDX_FLAGS, 8'h0);
        chk("flags reset", 8'h40, rq);
        apb(1'b1, DCT_IDX_FLAGS, 8'hbf);
        apb(1'b0, DCT_IDX_FLAGS, 8'h0);
        chk("flags write", 8'h00, rq);
        apb(1'b1, DCT_IDX_FLAGS, 8'h40);
        apb(1'b0, 8'h00, 8'h0);
        chk("unmapped", 8'h01, 8'(er));
        for (int i = 0; i < 8; i++) begin
            m = 2'(i >> 1);
            top = 1 + rnd() % 60;
            dv = rnd() % 8;
            n = rnd() % 300;
            apb(1'b1, DCT_IDX_CHVAL[2 * (i % 2)], 8'(top));
            apb(1'b1, DCT_IDX_CTL[i % 2], {dv[2:0], 3'b111, m});
            n1 = (i % 2) ? irq_n : irq_z;
            ticks(n);
            v = ((i % 2) ? irq_n : irq_z) - n1;
            n2 = exp_wrap(m, top, n >> dv);
            chk("wrap irq", 8'(n2), 8'(v));
            apb(1'b0, DCT_IDX_COUNT[i % 2], 8'h0);
            chk("count", exp_cnt(m, top, n >> dv), rq);
            k = rq;
            apb(1'b0, DCT_IDX_FLAGS, 8'h0);
            chk("wrap flag", 8'(n2 != 0), 8'(rq[3 * (i % 2)]));
            apb(1'b1, DCT_IDX_CTL[i % 2], 8'h08);
            ticks(3);
            apb(1'b0, DCT_IDX_COUNT[i % 2], 8'h0);
            chk("held count", 8'(k), rq);
            apb(1'b1, DCT_IDX_FLAGS, 8'h40);
            apb(1'b0, DCT_IDX_FLAGS, 8'h0);
            chk("flags cleared", 8'h40, rq);
        end
        for (int i = 0; i < 7; i++) begin
            a = 3'(i);
            v = 2 + rnd() % 100;
            apb(1'b1, DCT_IDX_T3_CTL, 8'h04);
            apb(1'b1, DCT_IDX_T3_CH0_CTL, {2'b00, a, 3'b100});
            apb(1'b1, DCT_IDX_T3_CH0_CTL, 8'h3c);
            chk("init out", 8'(a inside {3'd1, 3'd4, 3'd6}), 8'(chan_out[0]));
            apb(1'b0, DCT_IDX_T3_CH0_CTL, 8'h0);
            chk("kept action", {2'b00, a, 3'b100}, rq);
            apb(1'b1, DCT_IDX_T3_CH0_VAL, 8'(v));
            apb(1'b1, DCT_IDX_T3_CTL, {6'h04, 2'(3 * (i % 2))});
            ticks(v + 1);
            chk("match out", 8'(!(a inside {3'd1, 3'd4, 3'd6})), 8'(chan_out[0]));
        end
        apb(1'b1, DCT_IDX_T3_CH0_VAL, 8'hc3);
        apb(1'b0, DCT_IDX_T3_CH0_VAL, 8'h0);
        chk("pending value", 8'(v), rq);
        apb(1'b1, DCT_IDX_T3_CTL, 8'h04);
        apb(1'b0, DCT_IDX_T3_CH0_VAL, 8'h0);
        chk("applied value", 8'hc3, rq);
        for (int e = 0; e < 4; e++) begin
            n1 = 1 + rnd() % 50;
            n2 = 1 + rnd() % 50;
            apb(1'b1, DCT_IDX_T4_CH1_VAL, 8'h00);
            apb(1'b1, DCT_IDX_T4_CH1_CTL, {1'b0, e != 2, 4'h0, 2'(e)});
            apb(1'b1, DCT_IDX_T4_CTL, 8'h14);
            apb(1'b1, DCT_IDX_FLAGS, 8'h40);
            k = irq_n;
            ticks(n1);
            ext[3] <= 1'b1;
            repeat (8) @(posedge pclk);
            ticks(n2);
            ext[3] <= 1'b0;
            repeat (8) @(posedge pclk);
            apb(1'b0, DCT_IDX_T4_CH1_VAL, 8'h0);
            chk("snapshot", e == 0 ? 8'h00 : 8'(e == 1 ? n1 : n1 + n2), rq);
            apb(1'b0, DCT_IDX_FLAGS, 8'h0);
            chk("capture flag", 8'(e != 0), 8'(rq[5]));
            chk("irq count", 8'(e == 1 ? 1 : e == 3 ? 2 : 0), 8'(irq_n - k));
        end
        close_out();
    end
endmodule
